// file: logic/kps_keypad_ctrl.sv
// Purpose: Keypad size and scan-order registers, shared interrupt register and a small column scanner
// Assumes: APB slave, single clock, row inputs active low and synchronous
// Notes:   Registers at byte address four times their index; zero wait state
//
// Summary of operation
// RQ1: Size settings only used while automatic scanning is on
// RQ2: Three-bit row count field in bits 5:3 limits scanned rows
// RQ3: Three-bit column count field in bits 2:0 limits scanned columns
// RQ4: Scan order is five three-bit slots across two registers
// RQ5: Each slot names the column driven when that slot is reached
// RQ6: Slots stepped first to fifth, stopping after column count slots
// RQ7: Software loads zero to four for plain sequential scanning
// RQ8: Software reloads the order inside the key interrupt handler
// RQ9: Slots one, two and low part of three in low order register
// RQ10: Slot four bits 3:1, slot five bits 6:4 of high register
// RQ11: Bit 5 of shared register enables clock interrupt
// RQ12: Bit 4 flags clock interrupt, cleared by register read
// RQ13: Bit 3 is bus interrupt enable, bit 2 its flag
// RQ14: Bit 1 enables keypad interrupt
// RQ15: Bit 0 set on key found, cleared by register read
// RQ16: Bit 7 is read/write powerdown select, bit 6 unused
// RQ17: Scan enable selects automatic scanning, else bypass
// RQ18: Key found flag set on debounced press, cleared on read
// RQ19: Key found flag sets regardless of its interrupt enable
// RQ20: Debounce in 4ms steps, zero meaning 256ms
// RQ21: Interrupt asserted while any flag and its enable are set
// RQ22: Size and order fields reset to zero, read back as written
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "kps_cfg.svh"
module kps_keypad_ctrl
  import kps_pkg::*;
#(
  parameter int COL_CYC  = `KPS_COL_CYC,
  parameter int STEP_CYC = `KPS_DEB_STEP_CYC,
  parameter int ROWS     = 6,
  parameter int COLS     = 5
) (
  input  wire logic            clk_i,
  input  wire logic            arst_n_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [17:0]     paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  input  wire logic [ROWS-1:0] row_n_i,
  input  wire logic            clock_event_i,
  input  wire logic            bus_event_i,
  output logic      [COLS-1:0] col_n_o,
  output logic                 auto_scan_mode_o,
  output logic                 powerdown_select_o,
  output logic      [2:0]      key_row_o,
  output logic      [2:0]      key_col_o,
  output logic                 key_found_irq_o,
  output logic                 irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [7:0]  dim_r;
  logic [7:0]  ord_lo_r;
  logic [7:0]  ord_hi_r;
  logic [7:0]  scan_r;
  logic        pd_r;
  logic        clk_ien_r;
  logic        clk_flg_r;
  logic        bus_ien_r;
  logic        bus_flg_r;
  logic        key_ien_r;
  logic        key_flg_r;
  logic        key_found_r;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [15:0] idx;
  logic        hit_dim;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_irq;
  logic        hit_scan;
  logic        mapped;
  logic        rd_irq;
  logic        rd_scan;
  logic        key_evt;

  // Register address match
  function automatic logic hit(input logic [17:0] a, input logic [15:0] i);
    hit = (a[1:0] == 2'h0) && (a[17:2] == i);
  endfunction : hit

  assign acc      = psel_i & penable_i;
  assign wr       = acc & pwrite_i;
  assign rd       = acc & ~pwrite_i;
  assign idx      = paddr_i[17:2];
  assign hit_dim  = hit(paddr_i, `KPS_IDX_DIM);
  assign hit_lo   = hit(paddr_i, `KPS_IDX_ORD_LO);
  assign hit_hi   = hit(paddr_i, `KPS_IDX_ORD_HI);
  assign hit_irq  = hit(paddr_i, `KPS_IDX_IRQ);
  assign hit_scan = hit(paddr_i, `KPS_IDX_SCAN);
  assign mapped   = hit_dim | hit_lo | hit_hi | hit_irq | hit_scan;
  assign rd_irq   = rd & hit_irq;
  assign rd_scan  = rd & hit_scan;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // RQ22 reset and writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dim_r    <= `KPS_RST_DIM;
      ord_lo_r <= `KPS_RST_ORD;
      ord_hi_r <= `KPS_RST_ORD;
      scan_r   <= `KPS_RST_SCAN;
    end else if (wr) begin
      if (hit_dim) begin
        dim_r <= {2'h0, pwdata_i[5:0]};
      end
      if (hit_lo) begin
        ord_lo_r <= pwdata_i[7:0];
      end
      // RQ10 top bit unused
      if (hit_hi) begin
        ord_hi_r <= {1'b0, pwdata_i[6:0]};
      end
      if (hit_scan) begin
        scan_r <= {pwdata_i[7:1] , 1'b0} | {7'h00, pwdata_i[0]};
      end
    end
  end

  // RQ16 powerdown and enables
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pd_r      <= 1'b0;
      clk_ien_r <= 1'b0;
      bus_ien_r <= 1'b0;
      key_ien_r <= 1'b0;
    end else if (wr && hit_irq) begin
      pd_r      <= pwdata_i[`KPS_PD_BIT];
      // RQ11 clock enable
      clk_ien_r <= pwdata_i[`KPS_CLK_IEN_BIT];
      // RQ13 bus enable
      bus_ien_r <= pwdata_i[`KPS_BUS_IEN_BIT];
      // RQ14 keypad enable
      key_ien_r <= pwdata_i[`KPS_KEY_IEN2_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over read clear

  // RQ12 clock flag clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_flg_r <= 1'b0;
    end else if (clock_event_i) begin
      clk_flg_r <= 1'b1;
    end else if (rd_irq) begin
      clk_flg_r <= 1'b0;
    end
  end

  // RQ13 bus flag, cleared on read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_flg_r <= 1'b0;
    end else if (bus_event_i) begin
      bus_flg_r <= 1'b1;
    end else if (rd_irq) begin
      bus_flg_r <= 1'b0;
    end
  end

  // RQ15 keypad flag clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_flg_r <= 1'b0;
    end else if (key_evt) begin
      key_flg_r <= 1'b1;
    end else if (rd_irq) begin
      key_flg_r <= 1'b0;
    end
  end

  // RQ18 key found flag
  // RQ19 set regardless of enable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_found_r <= 1'b0;
    end else if (key_evt) begin
      key_found_r <= 1'b1;
    end else if (rd_scan) begin
      key_found_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scanner

  kps_state_e  state_r;
  logic [2:0]  slot_r;
  logic [31:0] tmr_r;
  logic [6:0]  steps_r;
  logic [2:0]  row_hit;
  logic        any_row;
  logic [2:0]  cur_col;
  logic [2:0]  col_lim;
  logic [2:0]  row_lim;
  logic [6:0]  deb_steps;
  logic        auto_en;
  logic [ROWS-1:0] row_mask;

  assign auto_en = scan_r[`KPS_SCAN_EN_BIT];

  // RQ1 size ignored in bypass
  // RQ3 column limit
  assign col_lim = (dim_r[2:0] == 3'h0 || dim_r[2:0] > 3'(COLS)) ? 3'(COLS) : dim_r[2:0];
  // RQ2 row limit
  assign row_lim = (dim_r[5:3] == 3'h0 || dim_r[5:3] > 3'(ROWS)) ? 3'(ROWS) : dim_r[5:3];
  // RQ20 zero means max
  assign deb_steps = (scan_r[6:1] == 6'h00) ? 7'(`KPS_DEB_MAX_STEPS) : {1'b0, scan_r[6:1]};

  // Row enable mask from row count
  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_row
      assign row_mask[g] = (3'(g) < row_lim);
    end
  endgenerate

  // Lowest pressed row
  always_comb begin
    row_hit = 3'h0;
    any_row = 1'b0;
    for (int i = ROWS - 1; i >= 0; i--) begin
      if (!row_n_i[i] && row_mask[i]) begin
        row_hit = 3'(i);
        any_row = 1'b1;
      end
    end
  end

  // RQ4 slot lookup
  // RQ9 low register layout
  kps_slot_sel u_slot (
    .order_i  ({ord_hi_r[6:0], ord_lo_r}),
    .slot_i   (slot_r),
    .column_o (cur_col)
  );

  assign key_evt = (state_r == KPS_DEBOUNCE) && (tmr_r == 32'(STEP_CYC - 1))
                   && (steps_r == deb_steps - 7'h1) && any_row;

  // RQ17 automatic or bypass
  // RQ6 step slots to limit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= KPS_IDLE;
      slot_r  <= 3'h0;
      tmr_r   <= 32'h0;
      steps_r <= 7'h0;
    end else if (!auto_en) begin
      state_r <= KPS_IDLE;
      slot_r  <= 3'h0;
      tmr_r   <= 32'h0;
      steps_r <= 7'h0;
    end else begin
      case (state_r)
        KPS_IDLE: begin
          state_r <= KPS_SCAN;
          slot_r  <= 3'h0;
          tmr_r   <= 32'h0;
        end
        KPS_SCAN: begin
          if (tmr_r == 32'(COL_CYC - 1)) begin
            tmr_r <= 32'h0;
            if (any_row) begin
              state_r <= KPS_DEBOUNCE;
              steps_r <= 7'h0;
            end else if (slot_r + 3'h1 >= col_lim) begin
              slot_r <= 3'h0;
            end else begin
              slot_r <= slot_r + 3'h1;
            end
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        KPS_DEBOUNCE: begin
          if (!any_row) begin
            state_r <= KPS_SCAN;
            tmr_r   <= 32'h0;
          end else if (tmr_r == 32'(STEP_CYC - 1)) begin
            tmr_r <= 32'h0;
            if (steps_r == deb_steps - 7'h1) begin
              state_r <= KPS_HOLD;
              steps_r <= 7'h0;
            end else begin
              steps_r <= steps_r + 7'h1;
            end
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        KPS_HOLD: begin
          // Release debounced over same period
          if (any_row) begin
            tmr_r   <= 32'h0;
            steps_r <= 7'h0;
          end else if (tmr_r == 32'(STEP_CYC - 1)) begin
            tmr_r <= 32'h0;
            if (steps_r == deb_steps - 7'h1) begin
              state_r <= KPS_SCAN;
              slot_r  <= 3'h0;
            end else begin
              steps_r <= steps_r + 7'h1;
            end
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        default: begin
          state_r <= KPS_IDLE;
        end
      endcase
    end
  end

  // Captured key location
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_row_o <= 3'h0;
      key_col_o <= 3'h0;
    end else if (key_evt) begin
      key_row_o <= row_hit;
      key_col_o <= cur_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // RQ5 drive named column
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      col_n_o <= '1;
    end else begin
      for (int c = 0; c < COLS; c++) begin
        col_n_o[c] <= !(auto_en && state_r != KPS_IDLE && cur_col == 3'(c));
      end
    end
  end

  // RQ21 gated interrupt request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o              <= 1'b0;
      key_found_irq_o    <= 1'b0;
      auto_scan_mode_o   <= 1'b0;
      powerdown_select_o <= 1'b0;
    end else begin
      irq_o              <= (clk_flg_r & clk_ien_r) | (bus_flg_r & bus_ien_r) | (key_flg_r & key_ien_r);
      key_found_irq_o    <= key_found_r & scan_r[`KPS_KEY_IEN_BIT];
      auto_scan_mode_o   <= auto_en;
      powerdown_select_o <= pd_r;
    end
  end

  // Read data and answer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o  <= 32'h0;
      if (psel_i && !penable_i && !pwrite_i) begin
        if (hit_dim) begin
          prdata_o <= {24'h0, dim_r};
        end else if (hit_lo) begin
          prdata_o <= {24'h0, ord_lo_r};
        end else if (hit_hi) begin
          prdata_o <= {24'h0, ord_hi_r};
        end else if (hit_irq) begin
          prdata_o <= {24'h0, pd_r, 1'b0, clk_ien_r, clk_flg_r, bus_ien_r, bus_flg_r, key_ien_r, key_flg_r};
        end else if (hit_scan) begin
          prdata_o <= {24'h0, scan_r[7:1], key_found_r};
        end
      end
    end
  end

  logic unused;
  assign unused = ^idx;

endmodule : kps_keypad_ctrl
`default_nettype wire

// file: logic/kps_cfg.svh
// Purpose: Register map, field positions and timing counts of the keypad scan configuration block
// Assumes: APB byte addresses are four times the printed register index
// Notes:   Definitions only
`ifndef KPS_CFG_SVH
`define KPS_CFG_SVH

// Printed register indices
`define KPS_IDX_DIM        16'h00d5
`define KPS_IDX_ORD_LO     16'h00d6
`define KPS_IDX_ORD_HI     16'h00d7
`define KPS_IDX_IRQ        16'hff94
`define KPS_IDX_SCAN       16'h00d0
// Reset values
`define KPS_RST_DIM        8'h00
`define KPS_RST_ORD        8'h00
`define KPS_RST_IRQ        8'h00
`define KPS_RST_SCAN       8'h00
// Dimension fields
`define KPS_ROW_LSB        3
`define KPS_COL_LSB        0
// Scan control fields
`define KPS_SCAN_EN_BIT    7
`define KPS_DEB_LSB        1
`define KPS_DEB_W          6
`define KPS_KEY_IEN_BIT    0
// Shared interrupt fields
`define KPS_PD_BIT         7
`define KPS_CLK_IEN_BIT    5
`define KPS_CLK_FLG_BIT    4
`define KPS_BUS_IEN_BIT    3
`define KPS_BUS_FLG_BIT    2
`define KPS_KEY_IEN2_BIT   1
`define KPS_KEY_FLG_BIT    0
// Timing
`define KPS_CLK_MHZ        100
`define KPS_COL_TIME_US    1000
`define KPS_COL_CYC        (`KPS_COL_TIME_US * `KPS_CLK_MHZ)
`define KPS_DEB_STEP_MS    4
`define KPS_DEB_STEP_CYC   (`KPS_DEB_STEP_MS * 1000 * `KPS_CLK_MHZ)
`define KPS_DEB_MAX_STEPS  64

`endif

// file: logic/kps_pkg.sv
// Purpose: Types shared by the keypad scan configuration block
// Assumes: Nothing
// Notes:   Numbers live in kps_cfg.svh
package kps_pkg;
  typedef enum logic [1:0] {
    KPS_IDLE,
    KPS_SCAN,
    KPS_DEBOUNCE,
    KPS_HOLD
  } kps_state_e;
  typedef logic [2:0] kps_slot_t;
endpackage : kps_pkg

// file: logic/kps_slot_sel.sv
// Purpose: Picks the column number held in one scan-order slot
// Assumes: Slots packed three bits each, first slot lowest
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module kps_slot_sel
  import kps_pkg::*;
(
  input  wire logic [14:0] order_i,
  input  wire logic [2:0]  slot_i,
  output logic      [2:0]  column_o
);
  // Slot extraction
  always_comb begin
    case (slot_i)
      3'h0:    column_o = order_i[2:0];
      3'h1:    column_o = order_i[5:3];
      3'h2:    column_o = order_i[8:6];
      3'h3:    column_o = order_i[11:9];
      3'h4:    column_o = order_i[14:12];
      default: column_o = 3'h0;
    endcase
  end
endmodule : kps_slot_sel
`default_nettype wire

// file: verif/kps_keypad_model.sv
// Purpose: Keypad switch matrix seen from the row and column pins
// Assumes: One key closed at a time, columns driven active low
// Notes:   Open rows read high, as if pulled up to the supply
`timescale 1ns/10ps
`default_nettype none
module kps_keypad_model #(
  parameter int ROWS = 6,
  parameter int COLS = 5
) (
  input  wire logic [COLS-1:0] col_n_i,
  input  wire logic            press_i,
  input  wire logic [2:0]      row_i,
  input  wire logic [2:0]      col_i,
  output logic      [ROWS-1:0] row_n_o
);
  // Closed key ties its row to its column while that column is low
  always_comb begin
    row_n_o = '1;
    if (press_i && !col_n_i[col_i]) row_n_o[row_i] = 1'b0;
  end
endmodule : kps_keypad_model
`default_nettype wire

// file: verif/kps_keypad_ctrl_monitor.sv
// Purpose: Bus answer and column drive checks on the keypad controller
// Assumes: Zero wait state slave, one clock domain
// Notes:   Bound into every controller instance
`timescale 1ns/10ps
`default_nettype none
module kps_keypad_ctrl_monitor #(
  parameter int COLS = 5
) (
  input wire logic            clk_i,
  input wire logic            arst_n_i,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pwrite_i,
  input wire logic [17:0]     paddr_i,
  input wire logic [31:0]     pwdata_i,
  input wire logic [31:0]     prdata_o,
  input wire logic            pready_o,
  input wire logic            pslverr_o,
  input wire logic [COLS-1:0] col_n_o,
  input wire logic            auto_scan_mode_o,
  input wire logic            powerdown_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Bus answers
  ready_pulse_a: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("ready not a single pulse after setup");
  bad_addr_a: assert property (psel_i && !penable_i && paddr_i == 18'h00100 |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped address not refused");
  idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data outside access");
  high_order_a: assert property (pready_o && paddr_i == 18'h0035c |-> prdata_o[31:7] == 25'h0)
    else $error("high order unused bits not zero");
  // Control copies of written bits
  powerdown_copy_a: assert property (psel_i && penable_i && pwrite_i && paddr_i == 18'h3fe50
    |=> ##1 powerdown_select_o == $past(pwdata_i[7], 2))
    else $error("powerdown select not following write");
  scan_copy_a: assert property (psel_i && penable_i && pwrite_i && paddr_i == 18'h00340
    |=> ##1 auto_scan_mode_o == $past(pwdata_i[7], 2))
    else $error("scan mode not following write");
  // Column drive
  bypass_cols_a: assert property (!auto_scan_mode_o [*3] |-> &col_n_o)
    else $error("column driven in bypass");
  single_col_a: assert property ($onehot0(~col_n_o))
    else $error("more than one column driven");
endmodule : kps_keypad_ctrl_monitor

bind kps_keypad_ctrl kps_keypad_ctrl_monitor #(.COLS(COLS)) u_mon (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .col_n_o(col_n_o),
  .auto_scan_mode_o(auto_scan_mode_o), .powerdown_select_o(powerdown_select_o)
);
`default_nettype wire

// file: verif/kps_keypad_ctrl_test.sv
// Purpose: Register, interrupt and scan checks of the keypad controller
// Assumes: Short scan and debounce counts set by parameter
// Notes:   Bus tasks wait for ready under a bound
`timescale 1ns/10ps
`default_nettype none
module kps_keypad_ctrl_test;
  localparam logic [17:0] A_DIM = 18'h00354, A_OLO = 18'h00358, A_OHI = 18'h0035c;
  localparam logic [17:0] A_IRQ = 18'h3fe50, A_SCN = 18'h00340, A_BAD = 18'h00100;
  logic        clk_i, arst_n_i, psel, penable, pwrite, clk_ev, bus_ev, press;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, err, scan_mode, pd_sel, kf_irq, irq;
  logic [5:0]  row_n;
  logic [4:0]  col_n;
  logic [2:0]  key_row, key_col, prow, pcol;
  int          err_count, tests_run, n;

  kps_keypad_ctrl #(.COL_CYC(4), .STEP_CYC(8)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .row_n_i(row_n), .clock_event_i(clk_ev), .bus_event_i(bus_ev), .col_n_o(col_n),
    .auto_scan_mode_o(scan_mode), .powerdown_select_o(pd_sel), .key_row_o(key_row),
    .key_col_o(key_col), .key_found_irq_o(kf_irq), .irq_o(irq));
  kps_keypad_model #(.ROWS(6), .COLS(5)) u_pad (
    .col_n_i(col_n), .press_i(press), .row_i(prow), .col_i(pcol), .row_n_o(row_n));

  /////////////////////////////////////////////////////////////////////////////
  // Verdict and compare
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin err_count++; stop_test(); end
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic rd(input string nm, input logic [17:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp(nm, exp, q);
  endtask : rd
  task automatic pulse(input logic which);
    if (which) bus_ev <= 1'b1; else clk_ev <= 1'b1;
    @(posedge clk_i);
    bus_ev <= 1'b0; clk_ev <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  /////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    err_count = 0; tests_run = 0; arst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h0; pwdata = 32'h0; clk_ev = 1'b0; bus_ev = 1'b0; press = 1'b0;
    prow = 3'h2; pcol = 3'h1;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd("dim reset", A_DIM, 32'h0);
    rd("olo reset", A_OLO, 32'h0);
    rd("ohi reset", A_OHI, 32'h0);
    rd("irq reset", A_IRQ, 32'h0);
    xfer(1'b1, A_DIM, 32'h2d); rd("dim", A_DIM, 32'h2d);
    xfer(1'b1, A_OLO, 32'hff); rd("olo", A_OLO, 32'hff);
    xfer(1'b1, A_OHI, 32'hff); rd("ohi", A_OHI, 32'h7f);
    xfer(1'b1, A_BAD, 32'hff); cmp("bad wr err", 32'h1, 32'(err));
    rd("bad rd", A_BAD, 32'h0); cmp("bad rd err", 32'h1, 32'(err));
    // Enabled events: flag, request, clear on read
    xfer(1'b1, A_IRQ, 32'hea); rd("irq ctl", A_IRQ, 32'haa);
    cmp("pd sel", 32'h1, 32'(pd_sel));
    for (n = 0; n < 2; n++) begin
      pulse(n[0]);
      cmp("irq on", 32'h1, 32'(irq));
      rd("irq flag", A_IRQ, n[0] ? 32'hae : 32'hba);
      rd("irq clr", A_IRQ, 32'haa);
      cmp("irq off", 32'h0, 32'(irq));
    end
    // Masked event still flags
    xfer(1'b1, A_IRQ, 32'h80);
    pulse(1'b0);
    cmp("irq mask", 32'h0, 32'(irq));
    rd("mask flag", A_IRQ, 32'h90);
    rd("mask clr", A_IRQ, 32'h80);
    // Two-slot scan, order 3 then 1, key at row 2 column 1
    xfer(1'b1, A_IRQ, 32'h02);
    xfer(1'b1, A_DIM, 32'h32);
    xfer(1'b1, A_OLO, 32'h0b);
    xfer(1'b1, A_OHI, 32'h00);
    press <= 1'b1;
    xfer(1'b1, A_SCN, 32'h83);
    for (n = 0; n < 2000 && kf_irq !== 1'b1; n++) begin
      @(posedge clk_i);
      if (col_n !== 5'h17 && col_n !== 5'h1d && col_n !== 5'h1f) cmp("col drive", 32'h1d, 32'(col_n));
    end
    if (kf_irq !== 1'b1) begin err_count++; stop_test(); end
    press <= 1'b0;
    cmp("key row", 32'h2, 32'(key_row));
    cmp("key col", 32'h1, 32'(key_col));
    repeat (2) @(posedge clk_i);
    cmp("key irq", 32'h1, 32'(irq));
    rd("key flag", A_IRQ, 32'h03);
    rd("scan flag", A_SCN, 32'h83);
    rd("scan clr", A_SCN, 32'h82);
    // Handler reloads a counting order, full size, key at row 4 column 4
    prow <= 3'h4;
    pcol <= 3'h4;
    xfer(1'b1, A_OLO, 32'h88);
    xfer(1'b1, A_OHI, 32'h46);
    rd("seq olo", A_OLO, 32'h88);
    rd("seq ohi", A_OHI, 32'h46);
    xfer(1'b1, A_DIM, 32'h00);
    press <= 1'b1;
    for (n = 0; n < 2000 && kf_irq !== 1'b1; n++) begin
      @(posedge clk_i);
      cmp("seq col drive", 32'h1, 32'($onehot0(~col_n)));
    end
    if (kf_irq !== 1'b1) begin err_count++; stop_test(); end
    press <= 1'b0;
    cmp("seq key row", 32'h4, 32'(key_row));
    cmp("seq key col", 32'h4, 32'(key_col));
    stop_test();
  end
endmodule : kps_keypad_ctrl_test
`default_nettype wire
